// *** design/pps_ctrl.sv ***
// profile position command word, move latching and state word
`default_nettype none
// Overview of operation
// (RQ1) family select codes 0 position, 1 speed, 2 torque, 10 fieldbus; default 10
// (RQ2) host writes 1 to mode object before commanding moves
// (RQ3) drive enabled only while command bits 0 to 3 are all one
// (RQ4) clearing command bit 2 requests a quick stop
// (RQ5) rising bit 4 latches target, start speed, speed, accel and decel
// (RQ6) bit 5 zero queues the move; one aborts current and starts new
// (RQ7) bit 6 zero absolute target, one relative increment
// (RQ8) one fault reset per rising edge of bit 7
// (RQ9) while bit 7 is one all other commands are ignored; here bit 8 still drives halt_req while enabled
// (RQ10) bit 8 one halts motion; zero releases the halt
// (RQ11) state bits 0,1,2,4,6 show the enable handshake
// (RQ12) state bit 3 shows fault, bit 7 shows alarm
// (RQ13) state bit 5 is zero while quick stop is active
// (RQ14) state bit 9 set once the command word has taken effect
// (RQ15) state bit 10 always reads one
// (RQ16) state bit 11 shows software position limit reached
// (RQ17) state bit 12 zero when a new move can be accepted
// (RQ18) state bit 13 one when following error exceeds threshold
// (RQ19) state bit 15 one after homing completed
// (RQ20) following error threshold is 32 bit read write, default 3145728
// (RQ21) state bits 8 and 14 read zero
// (RQ22) edges found by comparing each written command to previous value
module pps_ctrl
    import pps_pkg::*;
#(
    parameter int PW = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic obj_wr_en,
    input wire logic obj_rd_en,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_rvalid,
    output logic obj_rerr,
    input wire logic fault_in,
    input wire logic alarm_in,
    input wire logic sw_limit_in,
    input wire logic homing_done_in,
    input wire logic axis_stopped_in,
    input wire logic move_done_in,
    input wire logic [PW-1:0] pos_demand,
    input wire logic [PW-1:0] pos_feedback,
    output logic [PW-1:0] move_target,
    output logic move_relative,
    output logic [31:0] move_start_speed,
    output logic [31:0] move_speed,
    output logic [31:0] move_accel,
    output logic [31:0] move_decel,
    output logic move_start,
    output logic move_abort,
    output logic drive_enable,
    output logic quick_stop_req,
    output logic halt_req,
    output logic fault_reset,
    output logic [7:0] operating_family_select,
    output logic [15:0] drive_state_word
);
    logic [15:0] cmd_reg, cmd_next;
    logic [7:0] mode_reg, mode_next;
    logic [7:0] family_reg, family_next;
    logic [31:0] ferr_lim_reg, ferr_lim_next;
    logic [PW-1:0] target_reg, target_next;
    logic [31:0] sspeed_reg, sspeed_next;
    logic [31:0] speed_reg, speed_next;
    logic [31:0] accel_reg, accel_next;
    logic [31:0] decel_reg, decel_next;
    logic sp_edge_reg, sp_edge_next;
    logic frst_reg, frst_next;
    logic remote_reg, remote_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic rerr_reg, rerr_next;
    logic ferr_hit;

    // object writes and command edges
    always_comb begin
        cmd_next = cmd_reg;
        mode_next = mode_reg;
        family_next = family_reg;
        ferr_lim_next = ferr_lim_reg;
        target_next = target_reg;
        sspeed_next = sspeed_reg;
        speed_next = speed_reg;
        accel_next = accel_reg;
        decel_next = decel_reg;
        sp_edge_next = 1'b0;
        frst_next = 1'b0;
        remote_next = remote_reg;
        if (obj_wr_en) begin
            unique case (obj_index)
                IDX_CMD: begin
                    cmd_next = obj_wdata[15:0];
                    remote_next = 1'b1; // RQ14
                    frst_next = obj_wdata[CW_FAULT_RST] & ~cmd_reg[CW_FAULT_RST]; // RQ8 RQ22
                    sp_edge_next = obj_wdata[CW_NEW_SP] & ~cmd_reg[CW_NEW_SP] & ~obj_wdata[CW_FAULT_RST]; // RQ5 RQ9 RQ22
                end
                IDX_MODE: mode_next = obj_wdata[7:0];
                IDX_FAMILY: if (obj_wdata[7:0] inside {FAM_POSITION, FAM_SPEED, FAM_TORQUE, FAM_FIELDBUS}) begin
                    family_next = obj_wdata[7:0]; // RQ1
                end
                IDX_FERR_LIM: ferr_lim_next = obj_wdata; // RQ20
                IDX_TARGET: target_next = obj_wdata[PW-1:0];
                IDX_START_SPEED: sspeed_next = obj_wdata;
                IDX_SPEED: speed_next = obj_wdata;
                IDX_ACCEL: accel_next = obj_wdata;
                IDX_DECEL: decel_next = obj_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd_reg <= CMD_RST;
            mode_reg <= MODE_RST;
            family_reg <= FAMILY_RST;
            ferr_lim_reg <= FERR_LIM_RST;
            target_reg <= TARGET_RST[PW-1:0];
            sspeed_reg <= START_SPEED_RST;
            {speed_reg, accel_reg, decel_reg} <= {SPEED_RST, ACCEL_RST, DECEL_RST};
            {sp_edge_reg, frst_reg, remote_reg} <= 3'b000;
        end else begin
            cmd_reg <= cmd_next;
            mode_reg <= mode_next;
            family_reg <= family_next;
            ferr_lim_reg <= ferr_lim_next;
            target_reg <= target_next;
            sspeed_reg <= sspeed_next;
            {speed_reg, accel_reg, decel_reg} <= {speed_next, accel_next, decel_next};
            {sp_edge_reg, frst_reg, remote_reg} <= {sp_edge_next, frst_next, remote_next};
        end
    end

    // enable handshake
    pps_state_t st_reg, st_next;
    logic fault_reg, fault_next;

    always_comb begin
        fault_next = fault_in | (fault_reg & ~frst_reg); // RQ8
        st_next = st_reg;
        unique case (st_reg)
            ST_FAULT: if (!fault_reg) st_next = ST_DISABLED;
            default: begin
                if (fault_reg) begin
                    st_next = ST_FAULT;
                end else if (!cmd_reg[CW_FAULT_RST]) begin // RQ9
                    unique case (st_reg)
                        ST_DISABLED: if (cmd_reg[CW_EN_VOLT] && cmd_reg[CW_QSTOP]) st_next = ST_READY;
                        ST_READY: begin
                            if (!cmd_reg[CW_EN_VOLT] || !cmd_reg[CW_QSTOP]) st_next = ST_DISABLED;
                            else if (cmd_reg[CW_SWITCH_ON]) st_next = ST_SWITCHED_ON;
                        end
                        ST_SWITCHED_ON: begin
                            if (!cmd_reg[CW_EN_VOLT] || !cmd_reg[CW_QSTOP]) st_next = ST_DISABLED;
                            else if (!cmd_reg[CW_SWITCH_ON]) st_next = ST_READY;
                            else if (cmd_reg[CW_OP_EN]) st_next = ST_ENABLED; // RQ3
                        end
                        ST_ENABLED: begin
                            if (!cmd_reg[CW_EN_VOLT]) st_next = ST_DISABLED;
                            else if (!cmd_reg[CW_QSTOP]) st_next = ST_QSTOP; // RQ4
                            else if (!cmd_reg[CW_SWITCH_ON]) st_next = ST_READY;
                            else if (!cmd_reg[CW_OP_EN]) st_next = ST_SWITCHED_ON; // RQ3
                        end
                        ST_QSTOP: if (!cmd_reg[CW_EN_VOLT] || axis_stopped_in) st_next = ST_DISABLED;
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= ST_DISABLED;
            fault_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            fault_reg <= fault_next;
        end
    end

    // move latching and queueing
    logic op_ok, halt;
    logic active_reg, active_next;
    logic pend_reg, pend_next;
    logic [PW-1:0] p_target_reg, p_target_next, o_target_reg, o_target_next;
    logic p_rel_reg, p_rel_next, o_rel_reg, o_rel_next;
    logic [31:0] p_ss_reg, p_ss_next, o_ss_reg, o_ss_next;
    logic [31:0] p_sp_reg, p_sp_next, o_sp_reg, o_sp_next;
    logic [31:0] p_ac_reg, p_ac_next, o_ac_reg, o_ac_next;
    logic [31:0] p_dc_reg, p_dc_next, o_dc_reg, o_dc_next;
    logic start_reg, start_next, abort_reg, abort_next;
    logic idle;

    always_comb begin
        op_ok = (st_reg == ST_ENABLED) && (mode_reg == MODE_PROFILE_POS) && !cmd_reg[CW_FAULT_RST]; // RQ2 RQ3 RQ9
        halt = cmd_reg[CW_HALT]; // RQ10
        active_next = active_reg;
        pend_next = pend_reg;
        {p_target_next, p_rel_next, p_ss_next, p_sp_next, p_ac_next, p_dc_next} =
            {p_target_reg, p_rel_reg, p_ss_reg, p_sp_reg, p_ac_reg, p_dc_reg};
        {o_target_next, o_rel_next, o_ss_next, o_sp_next, o_ac_next, o_dc_next} =
            {o_target_reg, o_rel_reg, o_ss_reg, o_sp_reg, o_ac_reg, o_dc_reg};
        start_next = 1'b0;
        abort_next = 1'b0;
        idle = 1'b0;
        if (!op_ok) begin
            active_next = 1'b0;
            pend_next = 1'b0;
            abort_next = active_reg;
        end else begin
            if (move_done_in) active_next = 1'b0;
            idle = !active_next && !halt;
            if (sp_edge_reg) begin
                if ((cmd_reg[CW_IMMED] || idle) && !halt) begin // RQ6
                    {o_target_next, o_rel_next, o_ss_next, o_sp_next, o_ac_next, o_dc_next} =
                        {target_reg, cmd_reg[CW_REL], sspeed_reg, speed_reg, accel_reg, decel_reg}; // RQ5 RQ7
                    start_next = 1'b1;
                    abort_next = active_next; // RQ6
                    active_next = 1'b1;
                    pend_next = 1'b0;
                end else if (!pend_reg) begin
                    {p_target_next, p_rel_next, p_ss_next, p_sp_next, p_ac_next, p_dc_next} =
                        {target_reg, cmd_reg[CW_REL], sspeed_reg, speed_reg, accel_reg, decel_reg}; // RQ5 RQ7
                    pend_next = 1'b1; // RQ6
                end
            end else if (pend_reg && idle) begin
                {o_target_next, o_rel_next, o_ss_next, o_sp_next, o_ac_next, o_dc_next} =
                    {p_target_reg, p_rel_reg, p_ss_reg, p_sp_reg, p_ac_reg, p_dc_reg}; // RQ6
                start_next = 1'b1;
                active_next = 1'b1;
                pend_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {active_reg, pend_reg} <= 2'b00;
            {p_target_reg, p_rel_reg, p_ss_reg, p_sp_reg, p_ac_reg, p_dc_reg} <= '0;
            {o_target_reg, o_rel_reg, o_ss_reg, o_sp_reg, o_ac_reg, o_dc_reg} <= '0;
            {start_reg, abort_reg} <= 2'b00;
        end else begin
            {active_reg, pend_reg} <= {active_next, pend_next};
            {p_target_reg, p_rel_reg, p_ss_reg, p_sp_reg, p_ac_reg, p_dc_reg} <=
                {p_target_next, p_rel_next, p_ss_next, p_sp_next, p_ac_next, p_dc_next};
            {o_target_reg, o_rel_reg, o_ss_reg, o_sp_reg, o_ac_reg, o_dc_reg} <=
                {o_target_next, o_rel_next, o_ss_next, o_sp_next, o_ac_next, o_dc_next};
            {start_reg, abort_reg} <= {start_next, abort_next};
        end
    end

    pps_follow_err #(
        .W(PW)
    ) u_ferr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pos_demand(pos_demand),
        .pos_feedback(pos_feedback),
        .limit(ferr_lim_reg[PW-1:0]),
        .exceeded(ferr_hit)
    );
    // state word and drive outputs
    logic [15:0] sw_reg, sw_next;
    logic en_reg, en_next, qs_reg, qs_next, halt_reg, halt_next;

    always_comb begin
        sw_next = 16'h0000; // RQ21
        sw_next[SW_READY] = (st_reg == ST_READY) || (st_reg == ST_SWITCHED_ON) || (st_reg == ST_ENABLED); // RQ11
        sw_next[SW_SWITCHED_ON] = (st_reg == ST_SWITCHED_ON) || (st_reg == ST_ENABLED); // RQ11
        sw_next[SW_OP_EN] = (st_reg == ST_ENABLED); // RQ11
        sw_next[SW_FAULT] = fault_reg; // RQ12
        sw_next[SW_VOLT] = cmd_reg[CW_EN_VOLT] && (st_reg != ST_DISABLED) && (st_reg != ST_FAULT); // RQ11
        sw_next[SW_QSTOP_N] = (st_reg != ST_QSTOP); // RQ13
        sw_next[SW_ON_DISABLED] = (st_reg == ST_DISABLED); // RQ11
        sw_next[SW_ALARM] = alarm_in; // RQ12
        sw_next[SW_REMOTE] = remote_reg; // RQ14
        sw_next[SW_REACHED] = 1'b1; // RQ15
        sw_next[SW_LIMIT] = sw_limit_in; // RQ16
        sw_next[SW_SP_BUSY] = pend_next || !op_ok; // RQ17
        sw_next[SW_FERR] = ferr_hit; // RQ18
        sw_next[SW_HOMED] = homing_done_in; // RQ19
        en_next = (st_next == ST_ENABLED); // RQ3
        qs_next = (st_next == ST_QSTOP); // RQ4
        halt_next = cmd_reg[CW_HALT] && (st_reg == ST_ENABLED); // RQ10
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {sw_reg, en_reg, qs_reg, halt_reg} <= 19'h00000;
        end else begin
            {sw_reg, en_reg, qs_reg, halt_reg} <= {sw_next, en_next, qs_next, halt_next};
        end
    end

    // object reads
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = obj_rd_en;
        rerr_next = 1'b0;
        if (obj_rd_en) begin
            rdata_next = 32'h0000_0000;
            unique case (obj_index)
                IDX_CMD: rdata_next = {16'h0000, cmd_reg};
                IDX_STATE: rdata_next = {16'h0000, sw_reg};
                IDX_MODE, IDX_MODE_SHOW: rdata_next = {24'h00_0000, mode_reg};
                IDX_POS_FB: rdata_next = 32'(pos_feedback);
                IDX_FERR_LIM: rdata_next = ferr_lim_reg;
                IDX_TARGET: rdata_next = 32'(target_reg);
                IDX_START_SPEED: rdata_next = sspeed_reg;
                IDX_SPEED: rdata_next = speed_reg;
                IDX_ACCEL: rdata_next = accel_reg;
                IDX_DECEL: rdata_next = decel_reg;
                IDX_FAMILY: rdata_next = {24'h00_0000, family_reg};
                default: rerr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {rdata_reg, rvalid_reg, rerr_reg} <= 34'h000000000;
        end else begin
            {rdata_reg, rvalid_reg, rerr_reg} <= {rdata_next, rvalid_next, rerr_next};
        end
    end
    assign {obj_rdata, obj_rvalid, obj_rerr} = {rdata_reg, rvalid_reg, rerr_reg};
    assign {move_target, move_relative, move_start_speed, move_speed, move_accel, move_decel} =
        {o_target_reg, o_rel_reg, o_ss_reg, o_sp_reg, o_ac_reg, o_dc_reg};
    assign {move_start, move_abort, drive_enable, quick_stop_req, halt_req, fault_reset} =
        {start_reg, abort_reg, en_reg, qs_reg, halt_reg, frst_reg};
    assign {operating_family_select, drive_state_word} = {family_reg, sw_reg};
endmodule
`default_nettype wire

// *** design/pps_pkg.sv ***
// constants and types of the profile position command and status block
`default_nettype none
package pps_pkg;
    // object indices
    localparam logic [15:0] IDX_CMD = 16'h6040;
    localparam logic [15:0] IDX_STATE = 16'h6041;
    localparam logic [15:0] IDX_MODE = 16'h6060;
    localparam logic [15:0] IDX_MODE_SHOW = 16'h6061;
    localparam logic [15:0] IDX_POS_FB = 16'h6064;
    localparam logic [15:0] IDX_FERR_LIM = 16'h6065;
    localparam logic [15:0] IDX_TARGET = 16'h607A;
    localparam logic [15:0] IDX_SPEED = 16'h6081;
    localparam logic [15:0] IDX_ACCEL = 16'h6083;
    localparam logic [15:0] IDX_DECEL = 16'h6084;
    localparam logic [15:0] IDX_FAMILY = 16'h2000;
    localparam logic [15:0] IDX_START_SPEED = 16'h2001;
    // reset values
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [31:0] FERR_LIM_RST = 32'h0030_0000;
    localparam logic [31:0] TARGET_RST = 32'h0000_0000;
    localparam logic [31:0] SPEED_RST = 32'h001A_AAAB;
    localparam logic [31:0] ACCEL_RST = 32'h682A_AAAB;
    localparam logic [31:0] DECEL_RST = 32'h682A_AAAB;
    localparam logic [31:0] START_SPEED_RST = 32'h0000_0000;
    // operating family codes
    localparam logic [7:0] FAM_POSITION = 8'h00;
    localparam logic [7:0] FAM_SPEED = 8'h01;
    localparam logic [7:0] FAM_TORQUE = 8'h02;
    localparam logic [7:0] FAM_FIELDBUS = 8'h0A;
    localparam logic [7:0] FAMILY_RST = FAM_FIELDBUS;
    // mode of operation code
    localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
    // command word bits
    localparam int CW_SWITCH_ON = 0;
    localparam int CW_EN_VOLT = 1;
    localparam int CW_QSTOP = 2;
    localparam int CW_OP_EN = 3;
    localparam int CW_NEW_SP = 4;
    localparam int CW_IMMED = 5;
    localparam int CW_REL = 6;
    localparam int CW_FAULT_RST = 7;
    localparam int CW_HALT = 8;
    // state word bits
    localparam int SW_READY = 0;
    localparam int SW_SWITCHED_ON = 1;
    localparam int SW_OP_EN = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_VOLT = 4;
    localparam int SW_QSTOP_N = 5;
    localparam int SW_ON_DISABLED = 6;
    localparam int SW_ALARM = 7;
    localparam int SW_REMOTE = 9;
    localparam int SW_REACHED = 10;
    localparam int SW_LIMIT = 11;
    localparam int SW_SP_BUSY = 12;
    localparam int SW_FERR = 13;
    localparam int SW_HOMED = 15;
    typedef enum logic [2:0] {
        ST_DISABLED,
        ST_READY,
        ST_SWITCHED_ON,
        ST_ENABLED,
        ST_QSTOP,
        ST_FAULT
    } pps_state_t;
endpackage
`default_nettype wire

// *** design/pps_follow_err.sv ***
// following error monitor against a threshold
`default_nettype none
module pps_follow_err
    import pps_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] pos_demand,
    input wire logic [W-1:0] pos_feedback,
    input wire logic [W-1:0] limit,
    output logic exceeded
);
    logic exceeded_reg;
    logic exceeded_next;

    // magnitude of a signed difference
    function automatic logic [W:0] abs_diff(input logic [W-1:0] a, input logic [W-1:0] b);
        logic [W:0] d;
        d = {a[W-1], a} - {b[W-1], b};
        abs_diff = d[W] ? (~d + 1'b1) : d;
    endfunction

    always_comb begin
        exceeded_next = abs_diff(pos_demand, pos_feedback) > {1'b0, limit}; // RQ18
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            exceeded_reg <= 1'b0;
        end else begin
            exceeded_reg <= exceeded_next;
        end
    end

    assign exceeded = exceeded_reg;
endmodule
`default_nettype wire

// *** bench/pps_ctrl_sva.sv ***
// port assertions for the command and state word block
`default_nettype none
module pps_ctrl_chk
    import pps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic obj_wr_en,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    input wire logic fault_in,
    input wire logic sw_limit_in,
    input wire logic move_relative,
    input wire logic move_start,
    input wire logic drive_enable,
    input wire logic quick_stop_req,
    input wire logic fault_reset,
    input wire logic [7:0] operating_family_select,
    input wire logic [15:0] drive_state_word
);
    logic cw_wr;
    logic [15:0] cw_reg;
    logic [7:0] mode_reg;
    assign cw_wr = obj_wr_en && obj_index == IDX_CMD;
    always_ff @(posedge clk_sys) begin
        cw_reg <= !rst_n ? CMD_RST : cw_wr ? obj_wdata[15:0] : cw_reg;
        mode_reg <= !rst_n ? MODE_RST : obj_wr_en && obj_index == IDX_MODE ? obj_wdata[7:0] : mode_reg;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_fault_edge;
        cw_wr && obj_wdata[CW_FAULT_RST] && !cw_reg[CW_FAULT_RST];
    endsequence
    sequence s_move_now;
        cw_wr && obj_wdata[5:0] == 6'h3F && obj_wdata[8:7] == 2'h0 && !cw_reg[CW_NEW_SP] && !cw_reg[CW_HALT]
            && drive_enable && !drive_state_word[SW_SP_BUSY] && mode_reg == MODE_PROFILE_POS;
    endsequence
    chk_family_code: assert property (operating_family_select inside {8'h00, 8'h01, 8'h02, 8'h0A})
        else $error("family code bad");
    chk_reach_high: assert property ($past(rst_n) |-> drive_state_word[SW_REACHED])
        else $error("reached bit low");
    chk_spare_zero: assert property (drive_state_word[8] == 1'b0 && drive_state_word[14] == 1'b0)
        else $error("spare bits set");
    chk_fault_once: assert property (s_fault_edge |=> fault_reset ##1 !fault_reset)
        else $error("fault reset pulse wrong");
    chk_move_start: assert property (s_move_now |-> ##2 move_start)
        else $error("move not started");
    chk_move_kind: assert property (s_move_now |-> ##2 move_relative == $past(obj_wdata[CW_REL], 2))
        else $error("move kind wrong");
    chk_enable_cmd: assert property ($rose(drive_enable) |-> cw_reg[3:0] == 4'hF)
        else $error("enabled without command");
    chk_op_bit: assert property (drive_enable |-> ##[0:2] drive_state_word[SW_OP_EN])
        else $error("enabled bit missing");
    chk_qstop_bit: assert property (quick_stop_req |-> ##[0:2] !drive_state_word[SW_QSTOP_N])
        else $error("quick stop bit wrong");
    chk_fault_bit: assert property (fault_in [*4] |-> drive_state_word[SW_FAULT])
        else $error("fault bit missing");
    chk_limit_bit: assert property ($stable(sw_limit_in) [*3] |-> drive_state_word[SW_LIMIT] == sw_limit_in)
        else $error("limit bit wrong");
endmodule
`default_nettype wire

// *** bench/pps_traj_model.sv ***
// trajectory side model: ends moves and stops the axis after run_len cycles
`default_nettype none
module pps_traj_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic move_start,
    input wire logic move_abort,
    input wire logic quick_stop_req,
    input wire logic [7:0] run_len,
    output logic move_done_in = 1'b0,
    output logic axis_stopped_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left_reg = 8'h00;
    logic [7:0] stop_reg = 8'h00;
    always @(posedge clk_sys) begin
        if (!rst_n || move_start || move_abort) begin
            left_reg <= (rst_n && move_start) ? run_len : 8'h00;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
        move_done_in <= rst_n && !move_start && !move_abort && left_reg == 8'h01;
        stop_reg <= (!rst_n || !quick_stop_req) ? 8'h00 : (stop_reg == run_len ? stop_reg : stop_reg + 8'h01);
        axis_stopped_in <= rst_n && quick_stop_req && stop_reg == run_len;
    end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// top testbench of the command and state word block
`default_nettype none
module tb_top
    import pps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic obj_wr_en = 1'b0;
    logic obj_rd_en = 1'b0;
    logic [15:0] obj_index = 16'h0000;
    logic [31:0] obj_wdata = 32'h0000_0000;
    logic fault_in = 1'b0;
    logic alarm_in = 1'b0;
    logic sw_limit_in = 1'b0;
    logic homing_done_in = 1'b0;
    logic [31:0] pos_demand = 32'h0000_0000;
    logic [31:0] pos_feedback = 32'h0000_0000;
    logic [7:0] run_len = 8'h03;
    logic [31:0] obj_rdata, move_target, move_start_speed, move_speed, move_accel, move_decel, rd_val, t;
    logic obj_rvalid, obj_rerr, move_done_in, axis_stopped_in, move_relative, move_start, move_abort, rd_err;
    logic drive_enable, quick_stop_req, halt_req, fault_reset;
    logic [7:0] operating_family_select;
    logic [15:0] drive_state_word;
    logic [7:0] fams [5] = '{8'h00, 8'h01, 8'h02, 8'h0A, 8'h05};
    int num_errors = 0;
    int comparisons = 0;
    always #50 clk_sys = ~clk_sys;
    pps_ctrl #(.PW(32)) pps_ctrl_inst (.*);
    pps_traj_model pps_traj_model_inst (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] i, input logic [31:0] d);
        @(negedge clk_sys);
        {obj_wr_en, obj_index, obj_wdata} = {1'b1, i, d};
        @(negedge clk_sys);
        obj_wr_en = 1'b0;
        repeat (5) @(negedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] i);
        @(negedge clk_sys);
        {obj_rd_en, obj_index} = {1'b1, i};
        @(negedge clk_sys);
        obj_rd_en = 1'b0;
        check({31'h0, obj_rvalid}, 32'h1);
        {rd_err, rd_val} = {obj_rerr, obj_rdata};
    endtask
    task automatic state_bit(input int b, input logic e);
        rd(IDX_STATE);
        check({31'h0, rd_val[b]}, {31'h0, e});
    endtask
    function automatic logic [31:0] state_exp(input logic en);
        state_exp = {16'h0, homing_done_in, 3'h0, sw_limit_in, 3'h0, alarm_in, 7'h00} | (en ? 32'h0437 : 32'h1460);
    endfunction
    initial begin
        t = $urandom(32'h3112);
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(IDX_STATE);
        check(rd_val, state_exp(1'b0));
        rd(IDX_FERR_LIM);
        check(rd_val, 32'd3145728);
        rd(16'h1234);
        check({31'h0, rd_err}, 32'h1);
        for (int k = 0; k < 5; k++) begin
            wr(IDX_FAMILY, {24'h0, fams[k]});
            check({24'h0, operating_family_select}, k == 4 ? 32'h0A : {24'h0, fams[k]});
        end
        $display("test 1 done");
        wr(IDX_MODE, 32'h1);
        wr(IDX_CMD, 32'h6);
        wr(IDX_CMD, 32'h7);
        wr(IDX_CMD, 32'hF);
        check({31'h0, drive_enable}, 32'h1);
        rd(IDX_STATE);
        check(rd_val, state_exp(1'b1) | 32'h0200);
        for (int k = 0; k < 8; k++) begin
            t = $urandom;
            wr(IDX_TARGET, t);
            wr(IDX_SPEED, ~t);
            wr(IDX_CMD, 32'h0F | (k % 4) << 5);
            wr(IDX_CMD, 32'h1F | (k % 4) << 5);
            check(move_target, t);
            check(move_speed, ~t);
            check({31'h0, move_relative}, {31'h0, k[1]});
        end
        $display("test 2 done");
        run_len = 8'h28;
        for (int k = 0; k < 2; k++) begin
            wr(IDX_TARGET, t + k);
            wr(IDX_CMD, 32'h0F);
            wr(IDX_CMD, 32'h1F);
        end
        check(move_target, t);
        state_bit(SW_SP_BUSY, 1'b1);
        for (int n = 0; n <= 100 && move_start !== 1'b1; n++) begin
            @(negedge clk_sys);
            if (n == 100) begin
                num_errors++;
                tally_and_finish();
            end
        end
        check(move_target, t + 1);
        wr(IDX_TARGET, ~t);
        wr(IDX_CMD, 32'h2F);
        wr(IDX_CMD, 32'h3F);
        check(move_target, ~t);
        wr(IDX_CMD, 32'h10F);
        check({31'h0, halt_req}, 32'h1);
        wr(IDX_CMD, 32'h0F);
        check({31'h0, halt_req}, 32'h0);
        wr(IDX_TARGET, t);
        wr(IDX_CMD, 32'h8F);
        wr(IDX_CMD, 32'h9F);
        check(move_target, ~t);
        wr(IDX_CMD, 32'h0B);
        check({31'h0, quick_stop_req}, 32'h1);
        state_bit(SW_QSTOP_N, 1'b0);
        repeat (50) @(negedge clk_sys);
        check({31'h0, drive_enable}, 32'h0);
        $display("test 3 done");
        {alarm_in, sw_limit_in, homing_done_in} = 3'($urandom);
        fault_in = 1'b1;
        repeat (5) @(negedge clk_sys);
        rd(IDX_STATE);
        check(rd_val & 32'h8888, state_exp(1'b0) & 32'h8880 | 32'h8);
        fault_in = 1'b0;
        wr(IDX_CMD, 32'h80);
        state_bit(SW_FAULT, 1'b0);
        fault_in = 1'b1;
        @(negedge clk_sys);
        fault_in = 1'b0;
        wr(IDX_CMD, 32'h80);
        state_bit(SW_FAULT, 1'b1);
        wr(IDX_CMD, 32'h00);
        wr(IDX_CMD, 32'h80);
        state_bit(SW_FAULT, 1'b0);
        wr(IDX_FERR_LIM, 32'd100);
        pos_demand = $urandom & 32'h00FF_FFFF;
        for (int k = 0; k < 2; k++) begin
            pos_feedback = pos_demand - 32'd101 + k;
            repeat (3) @(negedge clk_sys);
            state_bit(SW_FERR, k == 0);
        end
        $display("test 4 done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        tally_and_finish();
    end
endmodule
bind pps_ctrl pps_ctrl_chk pps_ctrl_chk_inst (.*);
`default_nettype wire
